// ===== rtl/imu_dvel_output_and_gyro_bias_regs.sv
`timescale 1ns/1ps
// Summary of operation
// R01 - y velocity fraction word at 0x34, read only, no reset value.
// R02 - y velocity upper word at 0x36, twos complement, 400/2^15 per lsb.
// R03 - z velocity fraction word at 0x38, read only, no reset value.
// R04 - z velocity upper word at 0x3A, twos complement, zero is 0x0000.
// R05 - sixteen bit code spans 0x7FFF down to 0x8000, minus one lsb is 0xFFFF.
// R06 - upper and lower words form 32-bit twos complement, saturating at the ends.
// R07 - rate offset added right after factory correction, at 2000 Hz sample rate.
// R08 - factory coefficients stay hidden, only offsets are host visible.
// R09 - x rate offset lower word at 0x40, read write, resets to zero.
// R10 - x rate offset upper word at 0x42, read write, resets to zero.
// R11 - y rate offset lower word at 0x44, read write, resets to zero.
// R12 - y rate offset upper word at 0x46, read write, resets to zero.
// R13 - offset pair forms 32-bit value, upper word aligned to gyro output.
// R14 - velocity change is trapezoid sum over decimation setting plus one samples.
// R15 - both words of a velocity change come from the same update.
module imu_dvel_output_and_gyro_bias_regs #(
   parameter int unsigned SAMPLE_PERIOD_CYCLES = imu_regs_pkg::SAMPLE_PERIOD_CYCLES
) (
   input  wire logic        clk_sys,
   input  wire logic        reset,
   input  wire logic        spi_sclk,
   input  wire logic        spi_cs_n,
   input  wire logic        spi_mosi,
   output logic             spi_miso,
   output logic             spi_miso_oe,
   input  wire logic [15:0] accel_y,
   input  wire logic [15:0] accel_z,
   input  wire logic [15:0] gyro_x_factory,
   input  wire logic [15:0] gyro_y_factory,
   input  wire logic [15:0] decimation_setting,
   output logic      [31:0] gyro_x_corrected,
   output logic      [31:0] gyro_y_corrected,
   output logic             gyro_corrected_valid,
   output logic             velocity_update
);

   // pin synchroniser: bit 2 sclk, bit 1 cs_n, bit 0 mosi
   logic [2:0]                   pin_sync1;
   logic [2:0]                   pin_sync2;
   logic [2:0]                   pin_sync3;
   logic [2:0]                   pin_level;
   logic [2:0]                   pin_previous;
   logic [2:0]                   next_pin_level;
   logic                         sclk_rise;
   logic                         sclk_fall;
   logic                         cs_fall;
   logic                         cs_rise;

   imu_regs_pkg::link_state_type link_state;
   imu_regs_pkg::link_state_type next_link_state;
   logic [4:0]                   bit_count;
   logic [15:0]                  rx_shift;
   logic [15:0]                  tx_shift;
   logic [15:0]                  response;
   logic [4:0]                   next_bit_count;
   logic [15:0]                  next_rx_shift;
   logic [15:0]                  next_tx_shift;
   logic [15:0]                  next_response;
   logic                         next_spi_miso;
   logic                         next_spi_miso_oe;
   logic                         frame_end;
   logic                         frame_write;
   logic                         frame_read;
   logic [6:0]                   frame_addr;
   logic [6:0]                   frame_word_addr;

   logic [15:0]                  x_rate_offset_lower;
   logic [15:0]                  x_rate_offset_upper;
   logic [15:0]                  y_rate_offset_lower;
   logic [15:0]                  y_rate_offset_upper;
   logic [15:0]                  next_x_rate_offset_lower;
   logic [15:0]                  next_x_rate_offset_upper;
   logic [15:0]                  next_y_rate_offset_lower;
   logic [15:0]                  next_y_rate_offset_upper;
   logic [15:0]                  read_value;

   logic [15:0]                  tick_count;
   logic                         sample_tick;
   logic [15:0]                  next_tick_count;
   logic                         next_sample_tick;
   logic [31:0]                  next_gyro_x_corrected;
   logic [31:0]                  next_gyro_y_corrected;
   logic                         next_gyro_corrected_valid;
   logic                         next_velocity_update;

   logic [31:0]                  y_velocity_change;
   logic [31:0]                  z_velocity_change;
   logic                         y_update;
   logic                         z_update;

   // adds a 32-bit offset to a 16-bit rate placed in the upper word, clamped
   function automatic logic [31:0] add_rate_offset(input logic [15:0] rate,
                                                   input logic [31:0] offset);
      logic [32:0] sum;
      sum = {rate[15], rate, 16'h0000} + {offset[31], offset};
      if (sum[32] != sum[31]) begin
         add_rate_offset = sum[32] ? imu_regs_pkg::DVEL_MIN : imu_regs_pkg::DVEL_MAX;
      end else begin
         add_rate_offset = sum[31:0];
      end
   endfunction

   // synchroniser and edge detection
   always_comb begin
      // a change counts only once the second and third stage agree
      next_pin_level = (pin_sync2 & ~(pin_sync2 ^ pin_sync3))
                     | (pin_level & (pin_sync2 ^ pin_sync3));
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         pin_sync1    <= imu_regs_pkg::PIN_LEVEL_RESET;
         pin_sync2    <= imu_regs_pkg::PIN_LEVEL_RESET;
         pin_sync3    <= imu_regs_pkg::PIN_LEVEL_RESET;
         pin_level    <= imu_regs_pkg::PIN_LEVEL_RESET;
         pin_previous <= imu_regs_pkg::PIN_LEVEL_RESET;
      end else begin
         pin_sync1    <= {spi_sclk, spi_cs_n, spi_mosi};
         pin_sync2    <= pin_sync1;
         pin_sync3    <= pin_sync2;
         pin_level    <= next_pin_level;
         pin_previous <= pin_level;
      end
   end

   assign sclk_rise = pin_level[2] & ~pin_previous[2];
   assign sclk_fall = ~pin_level[2] & pin_previous[2];
   assign cs_fall   = ~pin_level[1] & pin_previous[1];
   assign cs_rise   = pin_level[1] & ~pin_previous[1];

   // only frames of at least sixteen clocks count, clocks past the sixteenth are ignored
   assign frame_end       = (link_state == imu_regs_pkg::LINK_FRAME) && cs_rise
                            && (bit_count == imu_regs_pkg::FRAME_BIT_COUNT);
   assign frame_write     = frame_end && rx_shift[imu_regs_pkg::FRAME_WRITE_BIT];
   assign frame_read      = frame_end && !rx_shift[imu_regs_pkg::FRAME_WRITE_BIT];
   assign frame_addr      = rx_shift[imu_regs_pkg::FRAME_ADDR_MSB:imu_regs_pkg::FRAME_ADDR_LSB];
   assign frame_word_addr = {frame_addr[6:1], 1'b0};

   // register read decode; factory coefficients have no address at all
   always_comb begin
      unique case (frame_word_addr)
         imu_regs_pkg::ADDR_Y_VELOCITY_FRACTION: read_value = y_velocity_change[15:0];  // R01
         imu_regs_pkg::ADDR_Y_VELOCITY_WORD:     read_value = y_velocity_change[31:16]; // R02 R05
         imu_regs_pkg::ADDR_Z_VELOCITY_FRACTION: read_value = z_velocity_change[15:0];  // R03
         imu_regs_pkg::ADDR_Z_VELOCITY_WORD:     read_value = z_velocity_change[31:16]; // R04
         imu_regs_pkg::ADDR_X_RATE_OFFSET_LOWER: read_value = x_rate_offset_lower; // R09
         imu_regs_pkg::ADDR_X_RATE_OFFSET_UPPER: read_value = x_rate_offset_upper; // R10
         imu_regs_pkg::ADDR_Y_RATE_OFFSET_LOWER: read_value = y_rate_offset_lower; // R11
         imu_regs_pkg::ADDR_Y_RATE_OFFSET_UPPER: read_value = y_rate_offset_upper; // R12
         default:                                read_value = imu_regs_pkg::READ_UNMAPPED_VALUE; // R08
      endcase
   end

   // serial link: mode 3, sample on rising sclk, shift out on falling sclk
   always_comb begin
      next_link_state  = link_state;
      next_bit_count   = bit_count;
      next_rx_shift    = rx_shift;
      next_tx_shift    = tx_shift;
      next_response    = response;
      next_spi_miso    = spi_miso;
      next_spi_miso_oe = spi_miso_oe;
      unique case (link_state)
         imu_regs_pkg::LINK_IDLE: begin
            if (cs_fall) begin
               next_link_state  = imu_regs_pkg::LINK_FRAME;
               next_bit_count   = 5'h00;
               next_tx_shift    = response;
               next_spi_miso_oe = 1'b1;
            end
         end
         imu_regs_pkg::LINK_FRAME: begin
            if (cs_rise) begin
               next_link_state  = imu_regs_pkg::LINK_IDLE;
               next_spi_miso    = 1'b0;
               next_spi_miso_oe = 1'b0;
               if (frame_read) begin
                  // shifted out in the next frame
                  next_response = read_value;
               end else if (frame_write) begin
                  next_response = imu_regs_pkg::READ_UNMAPPED_VALUE;
               end
            end else begin
               if (sclk_rise && (bit_count != imu_regs_pkg::FRAME_BIT_COUNT)) begin
                  next_rx_shift  = {rx_shift[14:0], pin_level[0]};
                  next_bit_count = bit_count + 5'h01;
               end
               if (sclk_fall) begin
                  next_spi_miso = tx_shift[15];
                  next_tx_shift = {tx_shift[14:0], 1'b0};
               end
            end
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         link_state  <= imu_regs_pkg::LINK_IDLE;
         bit_count   <= 5'h00;
         rx_shift    <= 16'h0000;
         tx_shift    <= 16'h0000;
         response    <= imu_regs_pkg::READ_UNMAPPED_VALUE;
         spi_miso    <= 1'b0;
         spi_miso_oe <= 1'b0;
      end else begin
         link_state  <= next_link_state;
         bit_count   <= next_bit_count;
         rx_shift    <= next_rx_shift;
         tx_shift    <= next_tx_shift;
         response    <= next_response;
         spi_miso    <= next_spi_miso;
         spi_miso_oe <= next_spi_miso_oe;
      end
   end

   // offset words take one byte per frame, odd address is the high byte
   always_comb begin
      next_x_rate_offset_lower = x_rate_offset_lower;
      next_x_rate_offset_upper = x_rate_offset_upper;
      next_y_rate_offset_lower = y_rate_offset_lower;
      next_y_rate_offset_upper = y_rate_offset_upper;
      if (frame_write) begin
         unique case (frame_word_addr)
            imu_regs_pkg::ADDR_X_RATE_OFFSET_LOWER: begin
               if (frame_addr[0]) next_x_rate_offset_lower[15:8] = rx_shift[7:0]; // R09
               else               next_x_rate_offset_lower[7:0]  = rx_shift[7:0]; // R09
            end
            imu_regs_pkg::ADDR_X_RATE_OFFSET_UPPER: begin
               if (frame_addr[0]) next_x_rate_offset_upper[15:8] = rx_shift[7:0]; // R10
               else               next_x_rate_offset_upper[7:0]  = rx_shift[7:0]; // R10
            end
            imu_regs_pkg::ADDR_Y_RATE_OFFSET_LOWER: begin
               if (frame_addr[0]) next_y_rate_offset_lower[15:8] = rx_shift[7:0]; // R11
               else               next_y_rate_offset_lower[7:0]  = rx_shift[7:0]; // R11
            end
            imu_regs_pkg::ADDR_Y_RATE_OFFSET_UPPER: begin
               if (frame_addr[0]) next_y_rate_offset_upper[15:8] = rx_shift[7:0]; // R12
               else               next_y_rate_offset_upper[7:0]  = rx_shift[7:0]; // R12
            end
            // velocity words are read only, writes to them are dropped
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         x_rate_offset_lower <= imu_regs_pkg::RATE_OFFSET_RESET; // R09
         x_rate_offset_upper <= imu_regs_pkg::RATE_OFFSET_RESET; // R10
         y_rate_offset_lower <= imu_regs_pkg::RATE_OFFSET_RESET; // R11
         y_rate_offset_upper <= imu_regs_pkg::RATE_OFFSET_RESET; // R12
      end else begin
         x_rate_offset_lower <= next_x_rate_offset_lower;
         x_rate_offset_upper <= next_x_rate_offset_upper;
         y_rate_offset_lower <= next_y_rate_offset_lower;
         y_rate_offset_upper <= next_y_rate_offset_upper;
      end
   end

   // internal sample clock and corrected rate outputs
   always_comb begin
      next_sample_tick          = 1'b0;
      next_tick_count           = tick_count + 16'h0001;
      next_gyro_x_corrected     = gyro_x_corrected;
      next_gyro_y_corrected     = gyro_y_corrected;
      next_gyro_corrected_valid = 1'b0;
      next_velocity_update      = y_update | z_update;
      if (tick_count == 16'(SAMPLE_PERIOD_CYCLES - 1)) begin // R07
         next_tick_count  = 16'h0000;
         next_sample_tick = 1'b1;
      end
      if (sample_tick) begin
         // offset goes in after the factory stage, before any later filtering
         next_gyro_x_corrected = add_rate_offset(gyro_x_factory,
                                    {x_rate_offset_upper, x_rate_offset_lower}); // R07 R13
         next_gyro_y_corrected = add_rate_offset(gyro_y_factory,
                                    {y_rate_offset_upper, y_rate_offset_lower}); // R07 R13
         next_gyro_corrected_valid = 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         tick_count           <= 16'h0000;
         sample_tick          <= 1'b0;
         gyro_x_corrected     <= imu_regs_pkg::VELOCITY_RESET;
         gyro_y_corrected     <= imu_regs_pkg::VELOCITY_RESET;
         gyro_corrected_valid <= 1'b0;
         velocity_update      <= 1'b0;
      end else begin
         tick_count           <= next_tick_count;
         sample_tick          <= next_sample_tick;
         gyro_x_corrected     <= next_gyro_x_corrected;
         gyro_y_corrected     <= next_gyro_y_corrected;
         gyro_corrected_valid <= next_gyro_corrected_valid;
         velocity_update      <= next_velocity_update;
      end
   end

   // one integrator per axis, one shared tick
   velocity_change_integrator y_integrator (
      .clk_sys            (clk_sys),
      .reset              (reset),
      .sample_tick        (sample_tick),
      .accel_sample       (accel_y),
      .decimation_setting (decimation_setting),
      .velocity_change    (y_velocity_change),
      .velocity_update    (y_update)
   );

   velocity_change_integrator z_integrator (
      .clk_sys            (clk_sys),
      .reset              (reset),
      .sample_tick        (sample_tick),
      .accel_sample       (accel_z),
      .decimation_setting (decimation_setting),
      .velocity_change    (z_velocity_change),
      .velocity_update    (z_update)
   );

endmodule

// ===== rtl/imu_regs_pkg.sv
package imu_regs_pkg;

   // register byte addresses, seven address bits on the serial frame
   localparam logic [6:0] ADDR_Y_VELOCITY_FRACTION = 7'h34;
   localparam logic [6:0] ADDR_Y_VELOCITY_WORD     = 7'h36;
   localparam logic [6:0] ADDR_Z_VELOCITY_FRACTION = 7'h38;
   localparam logic [6:0] ADDR_Z_VELOCITY_WORD     = 7'h3A;
   localparam logic [6:0] ADDR_X_RATE_OFFSET_LOWER = 7'h40;
   localparam logic [6:0] ADDR_X_RATE_OFFSET_UPPER = 7'h42;
   localparam logic [6:0] ADDR_Y_RATE_OFFSET_LOWER = 7'h44;
   localparam logic [6:0] ADDR_Y_RATE_OFFSET_UPPER = 7'h46;

   localparam logic [15:0] RATE_OFFSET_RESET   = 16'h0000;
   localparam logic [15:0] READ_UNMAPPED_VALUE = 16'h0000;
   localparam logic [31:0] VELOCITY_RESET      = 32'h00000000;

   // serial frame layout: write flag, address, write data byte
   localparam int          FRAME_WRITE_BIT = 15;
   localparam int          FRAME_ADDR_MSB  = 14;
   localparam int          FRAME_ADDR_LSB  = 8;
   localparam logic [4:0]  FRAME_BIT_COUNT = 5'h10;
   localparam logic [2:0]  PIN_LEVEL_RESET = 3'h6;

   // internal sample clock
   localparam int unsigned CLK_FREQ_HZ          = 50_000_000;
   localparam int unsigned SAMPLE_RATE_HZ       = 2000;
   localparam int unsigned SAMPLE_PERIOD_CYCLES = CLK_FREQ_HZ / SAMPLE_RATE_HZ;

   // velocity change integration
   localparam int          ACCEL_SUM_WIDTH = 34;
   localparam int          DVEL_GAIN_SHIFT = 15;
   localparam logic [15:0] DECIMATION_COUNT_RESET = 16'h0000;
   localparam logic [31:0] DVEL_MAX = 32'h7FFFFFFF;
   localparam logic [31:0] DVEL_MIN = 32'h80000000;

   typedef enum logic [1:0] {
      LINK_IDLE  = 2'b01,
      LINK_FRAME = 2'b10
   } link_state_type;

endpackage

// ===== rtl/velocity_change_integrator.sv
`timescale 1ns/1ps
module velocity_change_integrator (
   input  wire logic        clk_sys,
   input  wire logic        reset,
   input  wire logic        sample_tick,
   input  wire logic [15:0] accel_sample,
   input  wire logic [15:0] decimation_setting,
   output logic      [31:0] velocity_change,
   output logic             velocity_update
);

   localparam int WIDE = imu_regs_pkg::ACCEL_SUM_WIDTH + imu_regs_pkg::DVEL_GAIN_SHIFT;

   logic [15:0]                                accel_previous;
   logic [imu_regs_pkg::ACCEL_SUM_WIDTH-1:0]   accel_sum;
   logic [15:0]                                sample_count;
   logic [15:0]                                next_accel_previous;
   logic [imu_regs_pkg::ACCEL_SUM_WIDTH-1:0]   next_accel_sum;
   logic [15:0]                                next_sample_count;
   logic [31:0]                                next_velocity_change;
   logic                                       next_velocity_update;
   logic [imu_regs_pkg::ACCEL_SUM_WIDTH-1:0]   pair_sum;
   logic [imu_regs_pkg::ACCEL_SUM_WIDTH-1:0]   total;
   logic [WIDE-1:0]                            scaled;

   always_comb begin
      next_accel_previous  = accel_previous;
      next_accel_sum       = accel_sum;
      next_sample_count    = sample_count;
      next_velocity_change = velocity_change;
      next_velocity_update = 1'b0;
      // trapezoid step: current plus previous sample
      pair_sum = imu_regs_pkg::ACCEL_SUM_WIDTH'($signed(accel_sample))
               + imu_regs_pkg::ACCEL_SUM_WIDTH'($signed(accel_previous)); // R14
      total    = accel_sum + pair_sum; // R14
      // the 1/(2 fs) factor is folded into the fixed gain shift
      scaled   = {total, {imu_regs_pkg::DVEL_GAIN_SHIFT{1'b0}}};
      if (sample_tick) begin
         next_accel_previous = accel_sample;
         if (sample_count == decimation_setting) begin // R14
            next_accel_sum       = '0;
            next_sample_count    = imu_regs_pkg::DECIMATION_COUNT_RESET;
            next_velocity_update = 1'b1;
            // whole 32-bit result loads at once so both words match
            if (!scaled[WIDE-1] && (|scaled[WIDE-2:31])) begin // R15
               next_velocity_change = imu_regs_pkg::DVEL_MAX; // R06
            end else if (scaled[WIDE-1] && !(&scaled[WIDE-2:31])) begin
               next_velocity_change = imu_regs_pkg::DVEL_MIN; // R06
            end else begin
               next_velocity_change = scaled[31:0]; // R06
            end
         end else begin
            next_accel_sum    = total;
            next_sample_count = sample_count + 16'h0001;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         accel_previous  <= 16'h0000;
         accel_sum       <= '0;
         sample_count    <= imu_regs_pkg::DECIMATION_COUNT_RESET;
         velocity_change <= imu_regs_pkg::VELOCITY_RESET;
         velocity_update <= 1'b0;
      end else begin
         accel_previous  <= next_accel_previous;
         accel_sum       <= next_accel_sum;
         sample_count    <= next_sample_count;
         velocity_change <= next_velocity_change;
         velocity_update <= next_velocity_update;
      end
   end

endmodule

// ===== verif/imu_regs_assertions.sv
`timescale 1ns/1ps
module imu_regs_checker #(
   parameter int unsigned SAMPLE_PERIOD_CYCLES = 20
) (
   input wire logic        clk_sys,
   input wire logic        reset,
   input wire logic        spi_sclk,
   input wire logic        spi_cs_n,
   input wire logic        spi_mosi,
   input wire logic        spi_miso,
   input wire logic        spi_miso_oe,
   input wire logic [15:0] accel_y,
   input wire logic [15:0] accel_z,
   input wire logic [15:0] gyro_x_factory,
   input wire logic [15:0] gyro_y_factory,
   input wire logic [15:0] decimation_setting,
   input wire logic [31:0] gyro_x_corrected,
   input wire logic [31:0] gyro_y_corrected,
   input wire logic        gyro_corrected_valid,
   input wire logic        velocity_update
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);
   logic [31:0] gap;
   logic [16:0] ticks;
   logic        gap_seen;
   logic        vel_seen;
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         gap      <= '0;
         ticks    <= '0;
         gap_seen <= 1'b0;
         vel_seen <= 1'b0;
      end else begin
         gap      <= gyro_corrected_valid ? 32'h0 : gap + 32'h1;
         gap_seen <= gap_seen | gyro_corrected_valid;
         ticks    <= velocity_update ? {16'h0, gyro_corrected_valid} :
                     ticks + {16'h0, gyro_corrected_valid};
         vel_seen <= vel_seen | velocity_update;
      end
   end
   sequence frame_open;
      $fell(spi_cs_n);
   endsequence
   sequence frame_close;
      $rose(spi_cs_n);
   endsequence
   a_valid_single: assert property (gyro_corrected_valid |=> !gyro_corrected_valid)
      else $error("valid too long");
   a_tick_spacing: assert property (gyro_corrected_valid && gap_seen |->
      gap == SAMPLE_PERIOD_CYCLES - 1) else $error("tick spacing");
   a_gyro_hold: assert property (!gyro_corrected_valid |->
      $stable(gyro_x_corrected) && $stable(gyro_y_corrected)) else $error("gyro moved");
   a_vel_single: assert property (velocity_update |=> !velocity_update)
      else $error("update too long");
   a_vel_spacing: assert property (velocity_update && vel_seen |->
      ticks == {1'b0, decimation_setting} + 17'h1) else $error("decimation wrong");
   a_vel_on_tick: assert property (velocity_update |-> $past(gyro_corrected_valid))
      else $error("off tick");
   a_miso_quiet: assert property (!spi_miso_oe |-> !spi_miso)
      else $error("miso high undriven");
   a_oe_open: assert property (frame_open |-> ##[1:8] spi_miso_oe)
      else $error("miso enable late");
   a_oe_close: assert property (frame_close |-> ##[1:8] !spi_miso_oe)
      else $error("miso enable stuck");
endmodule
bind imu_dvel_output_and_gyro_bias_regs imu_regs_checker #(
   .SAMPLE_PERIOD_CYCLES(SAMPLE_PERIOD_CYCLES)
) watch (
   .clk_sys(clk_sys), .reset(reset), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
   .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
   .accel_y(accel_y), .accel_z(accel_z), .gyro_x_factory(gyro_x_factory),
   .gyro_y_factory(gyro_y_factory), .decimation_setting(decimation_setting),
   .gyro_x_corrected(gyro_x_corrected), .gyro_y_corrected(gyro_y_corrected),
   .gyro_corrected_valid(gyro_corrected_valid), .velocity_update(velocity_update)
);

// ===== verif/imu_spi_host.sv
`timescale 1ns/1ps
module imu_spi_host #(
   parameter int HALF = 10
) (
   input  wire logic clk_sys,
   input  wire logic spi_miso,
   input  wire logic spi_miso_oe,
   output logic      spi_sclk,
   output logic      spi_cs_n,
   output logic      spi_mosi
);
   // half period of ten clocks clears the sync delay
   initial begin
      spi_sclk = 1'b1;
      spi_cs_n = 1'b1;
      spi_mosi = 1'b0;
   end
   task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
      spi_cs_n = 1'b0;
      repeat (HALF) @(negedge clk_sys);
      for (int i = 15; i >= 0; i--) begin
         spi_sclk = 1'b0;
         spi_mosi = tx[i];
         repeat (HALF) @(negedge clk_sys);
         // unknown unless driven
         rx[i] = (spi_miso_oe === 1'b1) ? spi_miso : 1'bx;
         spi_sclk = 1'b1;
         repeat (HALF) @(negedge clk_sys);
      end
      spi_cs_n = 1'b1;
      spi_mosi = ~spi_mosi;
      repeat (HALF) @(negedge clk_sys);
   endtask
endmodule

// ===== verif/tb_imu_dvel_output_and_gyro_bias_regs.sv
`timescale 1ns/1ps
module tb_imu_dvel_output_and_gyro_bias_regs;
   localparam int unsigned PERIOD = 20;
   logic        clk_sys = 1'b0;
   logic        reset = 1'b1;
   logic        spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe;
   logic [15:0] accel_y = 16'h0123;
   logic [15:0] accel_z = 16'hFFFF;
   logic [15:0] gyro_x_factory = 16'h0100;
   logic [15:0] gyro_y_factory = 16'hFF00;
   logic [15:0] decimation_setting = 16'h0000;
   logic [31:0] gyro_x_corrected, gyro_y_corrected;
   logic        gyro_corrected_valid, velocity_update;
   logic [15:0] rd;
   logic [6:0]  addrs [4] = '{7'h40, 7'h42, 7'h44, 7'h46};
   logic [15:0] vals [4] = '{16'h1234, 16'h0002, 16'hFFFF, 16'hFFFE};
   int          mismatches = 0;
   int          checks_done = 0;
   int          cycles = 0;
   always #10 clk_sys = ~clk_sys;
   imu_dvel_output_and_gyro_bias_regs #(.SAMPLE_PERIOD_CYCLES(PERIOD)) dut (
      .clk_sys(clk_sys), .reset(reset), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
      .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
      .accel_y(accel_y), .accel_z(accel_z), .gyro_x_factory(gyro_x_factory),
      .gyro_y_factory(gyro_y_factory), .decimation_setting(decimation_setting),
      .gyro_x_corrected(gyro_x_corrected), .gyro_y_corrected(gyro_y_corrected),
      .gyro_corrected_valid(gyro_corrected_valid), .velocity_update(velocity_update));
   imu_spi_host host (.clk_sys(clk_sys), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
      .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi));
   task automatic close_out();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         mismatches++;
         close_out();
      end
   end
   task automatic cmp16(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic cmp32(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   // two byte frames, even byte first
   task automatic wr16(input logic [6:0] addr, input logic [15:0] data);
      logic [15:0] rx;
      host.xfer({1'b1, addr, data[7:0]}, rx);
      host.xfer({1'b1, addr | 7'h01, data[15:8]}, rx);
   endtask
   // answer comes in the next frame
   task automatic rd16(input logic [6:0] addr, output logic [15:0] data);
      logic [15:0] rx;
      host.xfer({1'b0, addr, 8'h00}, rx);
      host.xfer(16'h0000, data);
   endtask
   task automatic chk_vel(input logic [15:0] yw, yf, zw, zf);
      rd16(7'h36, rd);
      cmp16("y word", yw, rd);
      rd16(7'h34, rd);
      cmp16("y frac", yf, rd);
      rd16(7'h3A, rd);
      cmp16("z word", zw, rd);
      rd16(7'h38, rd);
      cmp16("z frac", zf, rd);
   endtask
   task automatic next_update();
      for (int i = 0; i < 3 * PERIOD; i++) begin
         @(negedge clk_sys);
         if (gyro_corrected_valid === 1'b1) break;
      end
   endtask
   initial begin
      repeat (2) @(negedge clk_sys);
      reset = 1'b0;
      repeat (5) @(negedge clk_sys);
      foreach (addrs[i]) begin
         rd16(addrs[i], rd);
         cmp16("offset reset", 16'h0000, rd);
      end
      $display("test offset_reset done");
      foreach (addrs[i]) wr16(addrs[i], vals[i]);
      wr16(7'h36, 16'h55AA);
      foreach (addrs[i]) begin
         rd16(addrs[i], rd);
         cmp16("offset readback", vals[i], rd);
      end
      rd16(7'h60, rd);
      cmp16("unmapped", 16'h0000, rd);
      chk_vel(16'h0123, 16'h0000, 16'hFFFF, 16'h0000);
      $display("test register_access done");
      next_update();
      cmp32("gyro x", 32'h01021234, gyro_x_corrected);
      cmp32("gyro y", 32'hFEFEFFFF, gyro_y_corrected);
      gyro_x_factory = 16'h7FFF;
      gyro_y_factory = 16'h8000;
      next_update();
      cmp32("gyro x sat", 32'h7FFFFFFF, gyro_x_corrected);
      cmp32("gyro y sat", 32'h80000000, gyro_y_corrected);
      $display("test gyro_offset done");
      // decimation changes only under reset
      reset = 1'b1;
      decimation_setting = 16'h0003;
      accel_y = 16'h7FFF;
      accel_z = 16'h8000;
      repeat (2) @(negedge clk_sys);
      reset = 1'b0;
      repeat (10 * PERIOD) @(negedge clk_sys);
      rd16(7'h42, rd);
      cmp16("offset after reset", 16'h0000, rd);
      next_update();
      cmp32("gyro x no offset", 32'h7FFF0000, gyro_x_corrected);
      chk_vel(16'h7FFF, 16'hFFFF, 16'h8000, 16'h0000);
      $display("test velocity_limits done");
      close_out();
   end
endmodule
